// ==== design/capture_compare_unit.sv ====
// Four channel capture/compare/PWM timer around one up-counter.
// Assumes software-side strobes and pins are synchronous to clock_i;
// configuration bits arrive as plain ports, held steady by software.
//
// Overview of operation
// - Four channels, each capture or compare
// - Counter counts up, free or modulo
// - Counter readable anytime without disturbing count
// - Seven prescaled rates or external pin
// - Active capture edge latches counter value
// - Capture edge rising, falling or either
// - Compare match sets, clears or toggles pin
// - Capture and compare events request interrupts
// - Link bit pairs 0/1, output on pin0
// - Last written set takes over at overflow
// - Linked: channel 1 unused, pin released
// - Pair 2/3 likewise, pin3 released
// - Toggle on overflow sets PWM period
// - Level select A picks PWM polarity
// - Modulo 255, divide one: 256 cycles
// - Compare only on exact equality
// - Compare flag ends pulse, overflow ends period
// - Mode 01 unbuffered, 1x buffered, B wins
// - Prescale all ones selects external clock
// - No overflow toggle gives zero duty
// - Overflow flag set at modulo, requests interrupt
`timescale 1ns/1ps

module capture_compare_unit
  import capture_compare_unit_pkg::*;
#(
  parameter int TIMER_W = TIMER_WIDTH,
  parameter int NUM_CH  = CHANNEL_COUNT
) (
  input  wire logic                clock_i,              // Bus clock, 10 MHz
  input  wire logic                resetn_i,             // Asynchronous reset, active low
  input  wire logic                counter_stop_i,       // Freezes counter and prescaler
  input  wire logic                counter_reset_i,      // Clears counter and prescaler
  input  wire logic [2:0]          prescale_select_i,    // Counter clock source
  input  wire logic [TIMER_W-1:0]  modulo_value_i,       // Counter wrap value
  input  wire logic                ext_count_clock_pin_i, // External count clock
  input  wire logic                overflow_irq_enable_i, // Overflow interrupt enable
  input  wire logic                overflow_clear_i,     // Clears overflow flag
  input  wire logic [2*NUM_CH-1:0] channel_mode_select_i, // B:A per channel
  input  wire logic [2*NUM_CH-1:0] edge_level_select_i,  // B:A per channel
  input  wire logic [NUM_CH-1:0]   toggle_on_overflow_i, // Toggle pin at overflow
  input  wire logic [NUM_CH-1:0]   channel_irq_enable_i, // Channel interrupt enables
  input  wire logic [NUM_CH-1:0]   channel_flag_clear_i, // Clears channel flags
  input  wire logic [NUM_CH-1:0]   channel_value_wr_i,   // Value register write strobes
  input  wire logic [TIMER_W-1:0]  channel_value_wdata_i, // Value write data
  input  wire logic [NUM_CH-1:0]   ch_pin_i,             // Channel pin levels
  output logic      [NUM_CH-1:0]   ch_pin_o,             // Channel pin drive levels
  output logic      [NUM_CH-1:0]   ch_pin_oe_o,          // High while the timer drives
  output logic [TIMER_W-1:0]       counter_value_o,      // Live counter value
  output logic [NUM_CH*TIMER_W-1:0] channel_value_o,     // Channel value registers
  output logic                     overflow_flag_o,      // Sticky overflow flag
  output logic [NUM_CH-1:0]        channel_flag_o,       // Sticky channel flags
  output logic                     overflow_irq_o,       // Overflow interrupt request
  output logic [NUM_CH-1:0]        channel_irq_o,        // Channel interrupt requests
  output logic [PAIR_COUNT-1:0]    pair_active_second_o  // Linked pair uses odd set
);

  // Prescaler tick for divide by two to the power of sel
  function automatic logic prescale_tick(input logic [2:0] sel, input logic [PRESCALE_WIDTH-1:0] pre);
    logic [PRESCALE_WIDTH-1:0] mask;
    mask = PRESCALE_WIDTH'((1 << sel) - 1);
    return (pre & mask) == mask;
  endfunction

  logic [PRESCALE_WIDTH-1:0] prescale;          // Free divider of the bus clock
  logic                      ext_prev;          // Previous external clock level
  logic                      tick;              // One counter step this cycle
  logic [TIMER_W-1:0]        counter;           // The timing reference
  logic                      overflow_event;    // Counter at modulo on a tick
  logic [TIMER_W-1:0]        value [NUM_CH];    // Channel value registers
  logic [NUM_CH-1:0]         pin_prev;          // Previous pin levels
  logic [NUM_CH-1:0]         capture_event;     // Active edge on a capture channel
  logic [NUM_CH-1:0]         compare_event;     // Exact match on a compare channel
  logic [NUM_CH-1:0]         is_compare;        // Channel in a compare mode
  logic [NUM_CH-1:0]         channel_unused;    // Odd channel of a linked pair
  logic [PAIR_COUNT-1:0]     linked;            // Pair buffer-link bits
  logic [PAIR_COUNT-1:0]     last_written_odd;  // Which set software wrote last
  logic [PAIR_COUNT-1:0]     active_odd;        // Which set governs the output
  logic [TIMER_W-1:0]        match_value [NUM_CH]; // Value compared per channel
  logic [NUM_CH-1:0]         pin_level;         // Output compare pin state

  // Pair links come from the upper mode bit of the even channel
  always_comb begin
    for (int p = 0; p < PAIR_COUNT; p++) begin
      linked[p] = channel_mode_select_i[2*(2*p)+MODE_BIT_B];
    end
  end

  // Mode decode per channel; upper bit outranks lower
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      channel_unused[c] = (c % 2 == 1) && linked[c/2];
      is_compare[c]     = !channel_unused[c] &&
                          (channel_mode_select_i[2*c+MODE_BIT_B] ||
                           channel_mode_select_i[2*c+MODE_BIT_A]);
    end
  end

  // Counter step enable; external pin counts on its rising edge
  always_comb begin
    if (counter_stop_i || counter_reset_i) begin
      tick = 1'b0;
    end else if (prescale_select_i == PS_EXTERNAL) begin
      tick = ext_count_clock_pin_i && !ext_prev;
    end else begin
      tick = prescale_tick(prescale_select_i, prescale);
    end
  end

  assign overflow_event = tick && (counter == modulo_value_i);

  // Prescaler divider; it restarts with the counter so periods are exact
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prescale <= PRESCALE_RESET;
    end else if (counter_reset_i) begin
      prescale <= PRESCALE_RESET;
    end else if (!counter_stop_i) begin
      prescale <= prescale + 1'b1;
    end
  end

  // Edge history for the external clock and the channel pins
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_prev <= 1'b0;
      pin_prev <= '0;
    end else begin
      ext_prev <= ext_count_clock_pin_i;
      pin_prev <= ch_pin_i;
    end
  end

  // Up-counter; wraps to zero the step after reaching modulo
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      counter <= COUNTER_RESET;
    end else if (counter_reset_i) begin
      counter <= COUNTER_RESET;
    end else if (overflow_event) begin
      counter <= COUNTER_RESET;
    end else if (tick) begin
      counter <= counter + 1'b1;
    end
  end

  // Reading is a plain wire from the counter, so it never disturbs counting
  assign counter_value_o = counter;

  // Capture edge detect, per channel edge select
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [1:0] els;
      logic       rise;
      logic       fall;
      els  = edge_level_select_i[2*c +: 2];
      rise = ch_pin_i[c] && !pin_prev[c];
      fall = !ch_pin_i[c] && pin_prev[c];
      capture_event[c] = !is_compare[c] && !channel_unused[c] &&
                         ((els == ELS_RISE_TOGGLE && rise) ||
                          (els == ELS_FALL_CLEAR && fall) ||
                          (els == ELS_BOTH_SET && (rise || fall)));
    end
  end

  // Compare source: a linked even channel uses the active set of its pair
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (c % 2 == 0 && linked[c/2] && active_odd[c/2]) begin
        match_value[c] = value[c | 1];                          // Odd partner, index stays in range
      end else begin
        match_value[c] = value[c];
      end
      compare_event[c] = is_compare[c] && tick && (counter == match_value[c]);
    end
  end

  // Value registers: software writes, captures overwrite; capture wins a clash
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        value[c] <= COUNTER_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (capture_event[c]) begin
          value[c] <= counter;
        end else if (channel_value_wr_i[c]) begin
          value[c] <= channel_value_wdata_i;
        end
      end
    end
  end

  // Pair bookkeeping; writing the active set acts unbuffered, as software
  // is expected to target only the idle set
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_written_odd <= '0;
      active_odd       <= '0;
    end else begin
      for (int p = 0; p < PAIR_COUNT; p++) begin
        if (!linked[p]) begin
          last_written_odd[p] <= 1'b0;                          // Even set governs first
          active_odd[p]       <= 1'b0;
        end else begin
          if (channel_value_wr_i[2*p+1]) begin
            last_written_odd[p] <= 1'b1;
          end else if (channel_value_wr_i[2*p]) begin
            last_written_odd[p] <= 1'b0;
          end
          if (overflow_event) begin
            active_odd[p] <= last_written_odd[p];
          end
        end
      end
    end
  end

  assign pair_active_second_o = active_odd;

  // Pin state; a compare in the same step as an overflow toggle wins,
  // which keeps a zero-width pulse correct at the period boundary
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_level <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!is_compare[c]) begin
          pin_level[c] <= 1'b0;
        end else if (compare_event[c]) begin
          case (edge_level_select_i[2*c +: 2])
            ELS_RISE_TOGGLE: pin_level[c] <= !pin_level[c];
            ELS_FALL_CLEAR:  pin_level[c] <= 1'b0;
            ELS_BOTH_SET:    pin_level[c] <= 1'b1;
            default:         pin_level[c] <= pin_level[c];
          endcase
        end else if (overflow_event && toggle_on_overflow_i[c]) begin
          pin_level[c] <= !pin_level[c];
        end
      end
    end
  end

  // Drive only compare channels with a pin action; released pins go to port logic
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_pin_o[c]    = pin_level[c];
      ch_pin_oe_o[c] = is_compare[c] && (edge_level_select_i[2*c +: 2] != ELS_OFF);
    end
  end

  // Sticky flags; a new event in the clearing cycle keeps the flag set
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overflow_flag_o <= 1'b0;
      channel_flag_o  <= '0;
    end else begin
      overflow_flag_o <= overflow_event || (overflow_flag_o && !overflow_clear_i);
      channel_flag_o  <= capture_event | compare_event |
                         (channel_flag_o & ~channel_flag_clear_i);
    end
  end

  // Interrupt requests are the flags gated by their enables; unused odd channels never request
  assign overflow_irq_o = overflow_flag_o && overflow_irq_enable_i;
  assign channel_irq_o  = channel_flag_o & channel_irq_enable_i & ~channel_unused;

  // Value registers exposed for software reads
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      channel_value_o[c*TIMER_W +: TIMER_W] = value[c];
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  // Divide by two: a tick, a gap, a tick, unless the rate or run state changes
  sequence s_two_cycle_tick;
    !tick ##1 (tick || prescale_select_i != 3'h1 || counter_stop_i || counter_reset_i);
  endsequence

  chk_counter_wrap_zero: assert property (
    overflow_event && !counter_reset_i |=> counter == COUNTER_RESET)
    else $error("counter did not wrap to zero after modulo");

  chk_counter_step_up: assert property (
    tick && !overflow_event |=> counter == $past(counter) + 1'b1)
    else $error("counter did not step by one");

  chk_counter_holds_idle: assert property (
    !tick && !counter_reset_i |=> counter == $past(counter))
    else $error("counter moved without a tick");

  chk_prescale_div_two: assert property (
    prescale_select_i == 3'h1 && tick ##1 prescale_select_i == 3'h1 && !counter_stop_i && !counter_reset_i
    |-> s_two_cycle_tick)
    else $error("divide by two prescale period wrong");

  chk_overflow_flag_set: assert property (
    overflow_event |=> overflow_flag_o)
    else $error("overflow flag not set at modulo");

  chk_capture_latch: assert property (
    capture_event[0] |=> value[0] == $past(counter))
    else $error("capture did not latch the counter");

  chk_compare_exact: assert property (
    compare_event[0] |-> counter == match_value[0])
    else $error("compare fired without equality");

  chk_compare_clear_pin: assert property (
    compare_event[0] && edge_level_select_i[1:0] == ELS_FALL_CLEAR ##1 is_compare[0] |-> !ch_pin_o[0])
    else $error("clear on compare left pin high");

  chk_link_releases_pin: assert property (
    linked[0] |-> !ch_pin_oe_o[1] && !channel_irq_o[1])
    else $error("linked odd channel still active");

  chk_pair_switch_overflow: assert property (
    linked[0] && overflow_event ##1 linked[0] |-> active_odd[0] == $past(last_written_odd[0]))
    else $error("pair did not switch at overflow");

  chk_ext_count_step: assert property (
    prescale_select_i == PS_EXTERNAL && ext_count_clock_pin_i && !ext_prev && !counter_stop_i && !counter_reset_i
    |=> counter == $past(counter) + 1'b1 || counter == COUNTER_RESET)
    else $error("external rising edge did not step the counter");

  chk_event_sets_flag: assert property (
    capture_event[0] || compare_event[0] |=> channel_flag_o[0])
    else $error("channel event did not set its flag");

  chk_overflow_toggle_pin: assert property (
    overflow_event && toggle_on_overflow_i[0] && is_compare[0] && !compare_event[0] ##1 is_compare[0]
    |-> ch_pin_o[0] != $past(ch_pin_o[0]))
    else $error("pin did not toggle at overflow");

endmodule

// ==== design/capture_compare_unit_pkg.sv ====
// Constants shared by the four channel capture/compare/PWM timer.
// Assumes a single bus clock; all slower rates are enable pulses.
package capture_compare_unit_pkg;

  // Counter and channel geometry
  localparam int          TIMER_WIDTH       = 16;
  localparam int          CHANNEL_COUNT     = 4;
  localparam int          PRESCALE_WIDTH    = 6;

  // Reset values
  localparam logic [15:0] COUNTER_RESET     = 16'h0000;
  localparam logic [15:0] MODULO_RESET      = 16'hffff;
  localparam logic [5:0]  PRESCALE_RESET    = 6'h00;

  // Prescale select codes; the all-ones code picks the external pin
  localparam logic [2:0]  PS_EXTERNAL       = 3'h7;

  // Channel mode select pair (upper bit links a pair)
  localparam int          MODE_BIT_A        = 0;
  localparam int          MODE_BIT_B        = 1;

  // Edge/level select codes, capture meaning / compare meaning
  localparam logic [1:0]  ELS_OFF           = 2'h0;
  localparam logic [1:0]  ELS_RISE_TOGGLE   = 2'h1;
  localparam logic [1:0]  ELS_FALL_CLEAR    = 2'h2;
  localparam logic [1:0]  ELS_BOTH_SET      = 2'h3;

  // Pair indices: first channel of each pair owns the linked output
  localparam int          PAIR_COUNT        = 2;

endpackage

// ==== testbench/pin_partner.sv ====
// Model of the event sources and loads on the four channel pins.
// Assumes the bench sets source levels at falling clock edges.
`timescale 1ns/1ps
module pin_partner (
  input  wire logic       clock_i, // Bus clock
  input  wire logic [3:0] src_i,   // Levels the event sources want
  input  wire logic       lag_i,   // Slow sources: one cycle late
  input  wire logic [3:0] drv_i,   // Timer drive levels
  input  wire logic [3:0] oe_i,    // Timer drive enables
  output logic      [3:0] pin_o    // Resolved pin levels
);
  logic [3:0] late; // Delayed copy of the source levels

  // Slow sources trail prompt ones by a cycle, so edge logic sees both
  always_ff @(posedge clock_i) begin
    late <= src_i;
  end

  // A pin the timer drives follows the timer, otherwise its source
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      pin_o[c] = oe_i[c] ? drv_i[c] : (lag_i ? late[c] : src_i[c]);
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the four channel capture/compare/PWM timer.
// Assumes the timer package, the timer and the pin partner are compiled first.
`timescale 1ns/1ps
module testbench;
  import capture_compare_unit_pkg::*;
  typedef struct { int kind; logic [15:0] exp; } note_t; // One expected result

  logic        clock_i, resetn_i, stop, crst, ext, ovf_ie, ovf_clr, lag; // Controls
  logic [2:0]  sel;                                   // Prescale select
  logic [15:0] modulo, wdata, measured, n_ext, v;     // Values and measurements
  logic [7:0]  mode, els;                             // Per channel B:A pairs
  logic [3:0]  tov, ie, fclr, wr, src, pins, pin_o, oe, cflag, cirq; // Per channel bits
  logic [15:0] cnt;                                   // Counter output
  logic [63:0] cval;                                  // Channel values
  logic        oflag, oirq;                           // Overflow outputs
  logic [1:0]  pair;                                  // Active set per pair
  int          miscompares = 0, n_checks = 0;         // Verdict counters
  note_t       q[$], cur;                             // Pending expectations
  string       names[14] = '{"counter", "pins", "pin_enables", "channel_flags", "overflow_flag",
    "overflow_irq", "channel_irqs", "pair_active", "value0", "value1", "value2", "value3", "measured", "pin0"};

  capture_compare_unit capture_compare_unit_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .counter_stop_i(stop), .counter_reset_i(crst),
    .prescale_select_i(sel), .modulo_value_i(modulo), .ext_count_clock_pin_i(ext),
    .overflow_irq_enable_i(ovf_ie), .overflow_clear_i(ovf_clr), .channel_mode_select_i(mode),
    .edge_level_select_i(els), .toggle_on_overflow_i(tov), .channel_irq_enable_i(ie),
    .channel_flag_clear_i(fclr), .channel_value_wr_i(wr), .channel_value_wdata_i(wdata),
    .ch_pin_i(pins), .ch_pin_o(pin_o), .ch_pin_oe_o(oe), .counter_value_o(cnt), .channel_value_o(cval),
    .overflow_flag_o(oflag), .channel_flag_o(cflag), .overflow_irq_o(oirq), .channel_irq_o(cirq),
    .pair_active_second_o(pair));

  pin_partner pin_partner_i (.clock_i(clock_i), .src_i(src), .lag_i(lag), .drv_i(pin_o), .oe_i(oe), .pin_o(pins));

  // Bus clock, 100 ns period
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // Picks the output that a note of a given kind refers to
  function automatic logic [15:0] seen(int k);
    case (k)
      0: return cnt;
      1: return {12'h000, pin_o};
      2: return {12'h000, oe};
      3: return {12'h000, cflag};
      4: return {15'h0000, oflag};
      5: return {15'h0000, oirq};
      6: return {12'h000, cirq};
      7: return {14'h0000, pair};
      12: return measured;
      13: return {15'h0000, pin_o[0]};
      default: return cval[16*(k-8) +: 16];
    endcase
  endfunction

  task automatic compare(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(int n); repeat (n) @(negedge clock_i); endtask
  task automatic note(int k, logic [15:0] e); q.push_back('{k, e}); endtask
  task automatic restart(); crst = 1'b1; tick(2); crst = 1'b0; endtask
  // A gap cycle after each write keeps the strobe from dropping and rising in one step
  task automatic write_ch(int c, logic [15:0] d); wr[c] = 1'b1; wdata = d; tick(1); wr = 4'h0; tick(1); endtask

  // Bounded wait on an output, then the value is noted for comparison
  task automatic wait_for(int k, logic [15:0] e, int lim);
    for (int i = 0; i < lim && seen(k) !== e; i++) tick(1);
    note(k, e);
  endtask

  // Counts the cycles of the next high pulse on pin 0
  task automatic high_time(logic [15:0] e);
    wait_for(13, 16'h0000, 600);
    wait_for(13, 16'h0001, 600);
    measured = 16'h0000;
    while (pin_o[0] === 1'b1 && measured < 16'h0258) begin measured++; tick(1); end
    note(12, e);
    tick(1);
  endtask

  // Watcher: compares the oldest notes once outputs have settled
  initial forever begin
    @(negedge clock_i);
    #10;
    while (q.size() > 0) begin
      cur = q.pop_front();
      compare(names[cur.kind], cur.exp, seen(cur.kind));
    end
  end

  // Watchdog: the whole run needs well under 20000 cycles
  initial begin
    #(20000 * 100);
    miscompares++;
    conclude();
  end

  // Main sequence
  initial begin
    {stop, ext, ovf_ie, ovf_clr, lag, sel, wdata, mode, els, tov, ie, fclr, wr, src} = '0;
    crst = 1'b1; modulo = 16'hffff; measured = 16'h0000; v = 16'h0000; resetn_i = 1'b0;
    void'($urandom(32'h29f0));
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    resetn_i = 1'b1;
    note(0, 16'h0000); note(3, 16'h0000); note(4, 16'h0000); note(7, 16'h0000); note(8, 16'h0000);
    // Modulo 2 wraps after three counts, flag and request follow
    modulo = 16'h0002; ovf_ie = 1'b1; crst = 1'b0;
    for (int i = 1; i <= 6; i++) begin tick(1); note(0, 16'(i % 3)); end
    note(4, 16'h0001); note(5, 16'h0001);
    stop = 1'b1; ovf_clr = 1'b1; tick(1); ovf_clr = 1'b0; ovf_ie = 1'b0;
    note(5, 16'h0000); note(4, 16'h0000); note(0, 16'h0000);
    // Every internal rate: one count per 2^s cycles
    stop = 1'b0; modulo = 16'hffff;
    for (int s = 0; s < 7; s++) begin
      sel = 3'(s); restart();
      wait_for(0, 16'h0001, 80); tick((1 << s) - 1); note(0, 16'h0001); tick(1); note(0, 16'h0002);
    end
    // External pin clocks the counter a random number of times
    sel = PS_EXTERNAL; restart(); n_ext = 16'($urandom_range(12, 3));
    repeat (n_ext) begin ext = 1'b1; tick(2); ext = 1'b0; tick(2); end
    note(0, n_ext);
    // Capture: rise, fall, both, off; counter stepped once between edges
    els = 8'b00_11_10_01; ie = 4'hf; src = 4'hf; tick(3);
    note(3, 16'h0005); note(6, 16'h0005); note(8, n_ext); note(10, n_ext); note(9, 16'h0000);
    note(2, 16'h0000); note(1, 16'h0000);
    fclr = 4'hf; tick(1); fclr = 4'h0; lag = 1'b1;
    ext = 1'b1; tick(2); ext = 1'b0; tick(2); src = 4'h0; tick(4);
    note(3, 16'h0006); note(9, n_ext + 16'h0001); note(10, n_ext + 16'h0001);
    // PWM with clear on compare; toggle on compare is avoided
    sel = 3'h0; modulo = 16'h00ff; mode = 8'h01; els = 8'h02; tov = 4'h1; ie = 4'h0;
    v = 16'($urandom_range(200, 1)); write_ch(0, v); restart();
    note(2, 16'h0001); high_time(v + 16'h0001);
    measured = 16'h0000;
    while (pin_o[0] === 1'b0 && measured < 16'h0258) begin measured++; tick(1); end
    note(12, 16'h00fe - v);
    tick(1);
    // Larger width written just after the overflow flag rises
    ovf_clr = 1'b1; tick(1); ovf_clr = 1'b0;
    wait_for(4, 16'h0001, 300); write_ch(0, v + 16'h0014);
    high_time(v + 16'h0015);
    tov = 4'h0; tick(300); measured = 16'h0000;
    repeat (260) begin if (pin_o[0] !== 1'b0) measured++; tick(1); end
    note(12, 16'h0000);
    // Linked pairs: B beats A, odd sets take over at overflow
    modulo = 16'h000f; tov = 4'h5; mode = 8'b01_11_01_10; els = 8'b11_10_01_10; restart();
    note(2, 16'h0005); note(7, 16'h0000);
    v = 16'($urandom_range(12, 2)); write_ch(1, v); write_ch(3, v);
    note(9, v); note(11, v); wait_for(7, 16'h0003, 40);
    high_time(v + 16'h0001);
    wait_for(13, 16'h0001, 40); note(1, 16'h0005);
    write_ch(0, 16'h0004); wait_for(7, 16'h0002, 40);
    tick(2);
    conclude();
  end
endmodule
